// ==== core/gcc_cfg.svh ====
/*
 Register offsets, field positions, reset values and limits of the global
 clock control block. Assumes inclusion by the package and the top module only.
*/
`ifndef GCC_CFG_SVH
`define GCC_CFG_SVH

`define GCC_OFS_CTRL 12'h000
`define GCC_OFS_STATIC 12'h004
`define GCC_OFS_STATUS 12'h008

`define GCC_CTRL_EN 0
`define GCC_CTRL_SEL_LO 1
`define GCC_CTRL_SEL_HI 2
`define GCC_CTRL_SWITCH 3
`define GCC_CTRL_RST 4'h0

`define GCC_ST_KIND_LO 0
`define GCC_ST_KIND_HI 1
`define GCC_ST_DP_PICK 2
`define GCC_ST_ROUTE0_LO 3
`define GCC_ST_ROUTE0_HI 6
`define GCC_ST_ROUTE1_LO 7
`define GCC_ST_ROUTE1_HI 10
`define GCC_ST_REF 11
`define GCC_ST_MANUAL 12
`define GCC_STATIC_RST 13'h0080

`define GCC_CNT_PER_PLL 5
`define GCC_MAX_NETS_GX 30
`define GCC_MAX_NETS_E 20
`define GCC_SMALL_LAST_NET 9
`define GCC_DP_GROUP_NET_A 8
`define GCC_DP_GROUP_NET_B 9

`define GCC_RESP_OKAY 2'h0
`define GCC_RESP_SLVERR 2'h2

`endif

// ==== core/gcc_pkg.sv ====
/*
 Types of the global clock control block: source kinds, dynamic select codes
 and the packed control, configuration and source words.
 Assumes gcc_cfg.svh is on the include path.
*/
package gcc_pkg;
`include "gcc_cfg.svh"

   typedef enum logic [1:0] {
      GCC_KIND_DYN = 2'b00,
      GCC_KIND_DP = 2'b01,
      GCC_KIND_FAB = 2'b10,
      GCC_KIND_RSV = 2'b11
   } gcc_kind_t;

   typedef enum logic [1:0] {
      GCC_SEL_PIN0 = 2'b00,
      GCC_SEL_PIN1 = 2'b01,
      GCC_SEL_PLL0 = 2'b10,
      GCC_SEL_PLL1 = 2'b11
   } gcc_sel_t;

   typedef struct packed {
      logic clk_switch;
      gcc_sel_t sel;
      logic enable;
   } gcc_ctrl_t;

   typedef struct packed {
      logic manual_switch;
      logic ref_static;
      logic [3:0] route1;
      logic [3:0] route0;
      logic dp_pick;
      gcc_kind_t kind;
   } gcc_static_t;

   typedef struct packed {
      logic fabric;
      logic [1:0] corner;
      logic [4:0] pll_b;
      logic [4:0] pll_a;
      logic [1:0] clk_pin;
      logic user_mode;
   } gcc_src_t;

endpackage : gcc_pkg

// ==== core/gcc_ctrl_top.sv ====
/*
 Global clock control block for one global_clock_net, with an AXI4-Lite
 register slave. Clock pins, PLL counters, corner pins, fabric source and the
 user-mode strap are sampled on REF_CLK_I after two flip-flops, so every
 source must toggle well below half of REF_CLK_I.
*/
// Function
// - Run-time source choice only among clock pins and PLL outputs.
// - Power-down gate disables and re-enables the global_clock_net at run time.
// - Fabric enable input passes or blocks the global clock; here the enable is CTRL bit 0, written over the bus.
// - Two-bit select chooses the dynamic source feeding the net.
// - Static source selection is frozen while in user mode.
// - Only two of the adjacent PLL counter outputs enter the block; here all ten enter and route0/route1 pick two.
// - Reference-switch mux makes pll_input_clock; select from config or run time.
// - Net feeds PLL input only when sourced from PLL or clock pin.
// - Dual-purpose or fabric sourced block never drives a PLL input.
// - Each PLL has five counters; at most two reach the net.
// - One corner_dual_purpose_pin of a pair feeds; the other stays ordinary I/O.
// - Left-side blocks of the larger transceiver variant take no clock pins.
// - Clock pins may carry clocks or global control signals onto the net.
// - Five or six blocks per side; at most 30 or 20 in total.
// - Block output drives exactly its own global_clock_net.
// - Smallest variants implement only global_clock_net 0 through 9.
// - Third dual-purpose pin group connects only to nets 8 and 9.
// - Unused clock pin feeds fabric through a logic_element_cell register only.
// - Enable sampled on the falling edge of the selected clock; here taken at every REF_CLK_I edge while that source is low.
// - Fabric input is selected statically, never dynamically.
// - Gating leaves PLL lock alone; output resumes without resynchronisation.
`timescale 1ns/1ps
`include "gcc_cfg.svh"

module gcc_ctrl_top #(
   parameter int NET_INDEX = 0,
   parameter bit GX_VARIANT = 1'b0,
   parameter bit LEFT_SIDE = 1'b0,
   parameter bit SMALL_DENSITY = 1'b0,
   parameter bit THIRD_DP_GROUP = 1'b0
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic ARST_N_I,
   // AXI4-Lite write address and data
   input wire logic [11:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   // AXI4-Lite write response
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // AXI4-Lite read
   input wire logic [11:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // Clock sources
   input wire gcc_pkg::gcc_src_t SRC_I,
   // Outputs to the network, the PLL and the fabric
   output logic GLOBAL_CLOCK_NET_O,
   output logic PLL_INPUT_CLOCK_O,
   output logic [1:0] CLK_PIN_FABRIC_O,
   output logic CORNER_GPIO_O
);
   import gcc_pkg::*;

   // Net existence fixed at build time
   localparam int MAX_NETS = GX_VARIANT ? `GCC_MAX_NETS_GX : `GCC_MAX_NETS_E;
   localparam bit NET_OK = (NET_INDEX >= 0) && (NET_INDEX < MAX_NETS) &&
      (!SMALL_DENSITY || NET_INDEX <= `GCC_SMALL_LAST_NET);
   localparam bit PINS_OK = !(GX_VARIANT && LEFT_SIDE);
   localparam bit DP_OK = !THIRD_DP_GROUP ||
      (NET_INDEX == `GCC_DP_GROUP_NET_A) || (NET_INDEX == `GCC_DP_GROUP_NET_B);
   localparam logic [4:0] NET_ID = NET_INDEX[4:0];

   // Picks one of ten counters; index 5 and above selects nothing
   function automatic logic pick_cnt(input logic [4:0] a, input logic [4:0] b,
                                     input logic [3:0] route);
      logic [2:0] idx;
      logic hit;
      idx = route[2:0];
      hit = 1'b0;
      if (idx < 3'(`GCC_CNT_PER_PLL)) begin
         hit = route[3] ? b[idx] : a[idx];
      end
      return hit;
   endfunction : pick_cnt

   // Register state
   gcc_ctrl_t ctrl_reg;
   gcc_static_t static_reg;
   gcc_src_t sync1_reg;
   gcc_src_t sync2_reg;
   logic sel_prev_reg;
   logic gate_reg;
   logic net_reg;
   logic pll_in_reg;
   logic [1:0] pin_fab_reg;
   logic corner_gpio_reg;

   // Bus state
   logic aw_held_reg;
   logic [11:0] aw_addr_reg;
   logic w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // Two-stage input synchroniser; only stage two is read by logic
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= SRC_I;
         sync2_reg <= sync1_reg;
      end
   end

   // Source selection
   wire logic user_mode = sync2_reg.user_mode;
   wire logic [1:0] pins = PINS_OK ? sync2_reg.clk_pin : 2'h0;
   wire logic route0 = pick_cnt(sync2_reg.pll_a, sync2_reg.pll_b, static_reg.route0);
   wire logic route1 = pick_cnt(sync2_reg.pll_a, sync2_reg.pll_b, static_reg.route1);
   wire logic dyn_src = (ctrl_reg.sel == GCC_SEL_PIN0) ? pins[0] :
      (ctrl_reg.sel == GCC_SEL_PIN1) ? pins[1] :
      (ctrl_reg.sel == GCC_SEL_PLL0) ? route0 : route1;
   wire logic corner_src = static_reg.dp_pick ? sync2_reg.corner[1] : sync2_reg.corner[0];
   wire logic corner_spare = static_reg.dp_pick ? sync2_reg.corner[0] : sync2_reg.corner[1];
   wire logic is_dyn = (static_reg.kind == GCC_KIND_DYN);
   wire logic is_dp = (static_reg.kind == GCC_KIND_DP) && DP_OK;
   wire logic is_fab = (static_reg.kind == GCC_KIND_FAB);
   wire logic sel_src = is_dyn ? dyn_src :
      is_dp ? corner_src :
      is_fab ? sync2_reg.fabric : 1'b0;
   wire logic pll_feed_ok = is_dyn;
   wire logic ref_sel = static_reg.manual_switch ? ctrl_reg.clk_switch : static_reg.ref_static;
   wire logic falling = sel_prev_reg && !sel_src;

   // Enable sampled while the selected source is low so a high phase is never cut short
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         sel_prev_reg <= 1'b0;
         gate_reg <= 1'b0;
      end else begin
         sel_prev_reg <= sel_src;
         if (falling || !sel_src) begin
            gate_reg <= ctrl_reg.enable;
         end
      end
   end

   // Gated net; the PLL path bypasses the gate so lock is never touched
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         net_reg <= 1'b0;
         pll_in_reg <= 1'b0;
         pin_fab_reg <= 2'h0;
         corner_gpio_reg <= 1'b0;
      end else begin
         net_reg <= NET_OK && gate_reg && sel_src;
         pll_in_reg <= ref_sel ? (pll_feed_ok && sel_src) : pins[0];
         pin_fab_reg <= pins;
         corner_gpio_reg <= corner_spare;
      end
   end

   assign GLOBAL_CLOCK_NET_O = net_reg;
   assign PLL_INPUT_CLOCK_O = pll_in_reg;
   assign CLK_PIN_FABRIC_O = pin_fab_reg;
   assign CORNER_GPIO_O = corner_gpio_reg;

   // Bus write path: address and data may come in either order
   wire logic aw_take = S_AXI_AWVALID_I && !aw_held_reg && !bvalid_reg;
   wire logic w_take = S_AXI_WVALID_I && !w_held_reg && !bvalid_reg;
   wire logic wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
   wire logic wr_ctrl = wr_do && (aw_addr_reg == `GCC_OFS_CTRL);
   wire logic wr_static = wr_do && (aw_addr_reg == `GCC_OFS_STATIC);
   wire logic wr_status = wr_do && (aw_addr_reg == `GCC_OFS_STATUS);
   wire logic wr_hit = wr_ctrl || wr_static || wr_status;
   wire logic static_locked = user_mode;
   wire logic [31:0] ctrl_word = {28'h0, ctrl_reg};
   wire logic [31:0] static_word = {19'h0, static_reg};
   wire logic [31:0] ctrl_new = (ctrl_word & ~strb_mask(w_strb_reg)) |
      (w_data_reg & strb_mask(w_strb_reg));
   wire logic [31:0] static_new = (static_word & ~strb_mask(w_strb_reg)) |
      (w_data_reg & strb_mask(w_strb_reg));

   // Byte strobes to a bit mask
   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return m;
   endfunction : strb_mask

   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR_I;
         end else if (wr_do) begin
            aw_held_reg <= 1'b0;
         end
         if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA_I;
            w_strb_reg <= S_AXI_WSTRB_I;
         end else if (wr_do) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // Registers and write response
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ctrl_reg <= gcc_ctrl_t'(`GCC_CTRL_RST);
         static_reg <= gcc_static_t'(`GCC_STATIC_RST);
         bvalid_reg <= 1'b0;
         bresp_reg <= `GCC_RESP_OKAY;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= gcc_ctrl_t'(ctrl_new[3:0]);
         end
         if (wr_static && !static_locked) begin
            static_reg <= gcc_static_t'(static_new[12:0]);
         end
         if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `GCC_RESP_OKAY : `GCC_RESP_SLVERR;
         end else if (S_AXI_BREADY_I) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   assign S_AXI_AWREADY_O = !aw_held_reg && !bvalid_reg;
   assign S_AXI_WREADY_O = !w_held_reg && !bvalid_reg;
   assign S_AXI_BVALID_O = bvalid_reg;
   assign S_AXI_BRESP_O = bresp_reg;

   // Read path; status write is accepted and has no effect
   wire logic rd_take = S_AXI_ARVALID_I && !rvalid_reg;
   wire logic [31:0] status_word = {22'h0, NET_ID, user_mode, pll_feed_ok,
      ctrl_reg.sel, gate_reg};
   wire logic rd_ctrl = (S_AXI_ARADDR_I == `GCC_OFS_CTRL);
   wire logic rd_static = (S_AXI_ARADDR_I == `GCC_OFS_STATIC);
   wire logic rd_status = (S_AXI_ARADDR_I == `GCC_OFS_STATUS);
   wire logic [31:0] rd_word = rd_ctrl ? ctrl_word :
      rd_static ? static_word :
      rd_status ? status_word : 32'h0;
   wire logic rd_hit = rd_ctrl || rd_static || rd_status;

   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= `GCC_RESP_OKAY;
      end else begin
         if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_hit ? `GCC_RESP_OKAY : `GCC_RESP_SLVERR;
         end else if (S_AXI_RREADY_I) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   assign S_AXI_ARREADY_O = !rvalid_reg;
   assign S_AXI_RVALID_O = rvalid_reg;
   assign S_AXI_RDATA_O = rdata_reg;
   assign S_AXI_RRESP_O = rresp_reg;

endmodule : gcc_ctrl_top

// ==== testbench/gcc_ctrl_sva.sv ====
/*
 Port-level checks of the global clock control block.
 Assumes a bind onto gcc_ctrl_top and one clock domain.
*/
`timescale 1ns/1ps
module gcc_ctrl_sva #(
   parameter bit GX_VARIANT = 1'b0,
   parameter bit LEFT_SIDE = 1'b0
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic ARST_N_I,
   // Bus handshakes
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // Sources and outputs
   input wire gcc_pkg::gcc_src_t SRC_I,
   input wire logic GLOBAL_CLOCK_NET_O,
   input wire logic PLL_INPUT_CLOCK_O,
   input wire logic [1:0] CLK_PIN_FABRIC_O
);
   import gcc_pkg::*;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   sequence aw_w_taken;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
   endsequence
   // Sync depth may differ by one edge, so a small span of history is accepted
   sequence src_was_high;
      ($past(SRC_I[15:1], 2) | $past(SRC_I[15:1], 3) | $past(SRC_I[15:1], 4)) != 15'h0;
   endsequence
   bvalid_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
      |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("Write response dropped");
   rvalid_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
      |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("Read data dropped");
   read_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("Read not answered");
   write_answer_a: assert property (aw_w_taken |-> ##[1:2] S_AXI_BVALID_O)
      else $error("Write not answered");
   busy_refuse_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
      else $error("Write taken while response pending");
   net_cause_a: assert property ($rose(GLOBAL_CLOCK_NET_O) |-> src_was_high)
      else $error("Net rose with no source high");
   pll_cause_a: assert property ($rose(PLL_INPUT_CLOCK_O) |-> src_was_high)
      else $error("PLL input rose with no source high");
   pin_copy_a: assert property ($stable(SRC_I.clk_pin[1])[*4] |->
      CLK_PIN_FABRIC_O[1] == (SRC_I.clk_pin[1] && !(GX_VARIANT && LEFT_SIDE)))
      else $error("Clock pin copy to fabric wrong");
endmodule : gcc_ctrl_sva

// ==== testbench/gcc_src_model.sv ====
/*
 Far-side model: clock pins, two PLLs of five counters, corner pins, fabric.
 Assumes the bench clock; each source has its own period dividing 840 cycles.
*/
`timescale 1ns/1ps
module gcc_src_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Strap and sources
   input wire logic user_mode_i,
   output gcc_pkg::gcc_src_t src_o
);
   import gcc_pkg::*;
   localparam int HALF [15] = '{4, 5, 6, 7, 10, 12, 14, 15, 20, 21, 28, 30, 35, 42, 60};
   logic [14:0] lvl_reg;
   int cnt_reg [15];
   // Periods stay at 8 cycles or more so the double sync sees every phase
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lvl_reg <= 15'h0;
         for (int j = 0; j < 15; j++) begin
            cnt_reg[j] <= 0;
         end
      end else begin
         for (int j = 0; j < 15; j++) begin
            if (cnt_reg[j] == HALF[j] - 1) begin
               lvl_reg[j] <= ~lvl_reg[j];
               cnt_reg[j] <= 0;
            end else begin
               cnt_reg[j] <= cnt_reg[j] + 1;
            end
         end
      end
   end
   assign src_o = {lvl_reg, user_mode_i};
endmodule : gcc_src_model

// ==== testbench/global_clock_control_block_test.sv ====
/*
 Register-level bench of the global clock control block.
 Assumes the source model and the checker are compiled beforehand.
*/
`timescale 1ns/1ps
module global_clock_control_block_test;
   import gcc_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0;
   logic arv = 1'h0, rready = 1'h0, um = 1'h0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] bresp, rresp, rs, pinf;
   logic awready, wready, bvalid, arready, rvalid, net, pll, gpio;
   gcc_src_t src;
   int errors = 0, n_compared = 0, cn, cp, cg;
   int exp_sel [4] = '{105, 84, 70, 60};
   logic [31:0] st [8] = '{32'hD8, 32'hA8, 32'h882, 32'h81, 32'h880, 32'h1880, 32'h1080,
      32'h85};
   logic [31:0] ct [8] = '{32'h5, 32'h5, 32'h5, 32'h5, 32'h3, 32'h3, 32'hB, 32'h5};
   int en [8] = '{15, 0, 7, 12, 84, 84, 84, 10};
   int ep [8] = '{105, 105, 0, 105, 84, 105, 84, 105};
   int eg [8] = '{10, 10, 10, 10, 10, 10, 10, 12};
   initial forever #20 clk = ~clk;
   gcc_src_model partner (.clk_i(clk), .arst_n_i(rst_n), .user_mode_i(um), .src_o(src));
   gcc_ctrl_top #(.NET_INDEX(3)) dut (
      .REF_CLK_I(clk), .ARST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready), .SRC_I(src), .GLOBAL_CLOCK_NET_O(net),
      .PLL_INPUT_CLOCK_O(pll), .CLK_PIN_FABRIC_O(pinf), .CORNER_GPIO_O(gpio));
   task automatic close_out;
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Handshakes are judged at the falling edge, released after the next rising one;
   // each call opens on a fresh rising edge so a release never meets a new request
   task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d);
      int n;
      logic ah, wh, dh;
      n = 0;
      @(posedge clk);
      if (w) begin
         awaddr <= a; wdata <= d; awv <= 1'h1; wv <= 1'h1; bready <= 1'h1;
      end else begin
         araddr <= a; arv <= 1'h1; rready <= 1'h1;
      end
      do begin
         @(negedge clk);
         ah = (awv & awready) | (arv & arready);
         wh = wv & wready;
         dh = w ? bvalid : rvalid;
         rs = w ? bresp : rresp;
         rd = rdata;
         @(posedge clk);
         if (ah) begin
            awv <= 1'h0; arv <= 1'h0;
         end
         if (wh) wv <= 1'h0;
         n++;
      end while (!dh && n < 200);
      bready <= 1'h0; rready <= 1'h0;
      if (n >= 200) begin
         errors++;
         close_out();
      end
   endtask : xfer
   // 840 cycles hold a whole number of periods of every source
   task automatic meas;
      logic pn, pp, pg;
      repeat (20) @(posedge clk);
      cn = 0; cp = 0; cg = 0;
      #1 pn = net; pp = pll; pg = gpio;
      repeat (840) begin
         @(posedge clk);
         #1 cn += int'(net & !pn);
         cp += int'(pll & !pp);
         cg += int'(gpio & !pg);
         pn = net; pp = pll; pg = gpio;
      end
   endtask : meas
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      xfer(0, 12'h000, 32'h0); chk("ctrl reset", 32'h0, rd);
      xfer(0, 12'h004, 32'h0); chk("static reset", 32'h80, rd);
      xfer(0, 12'h008, 32'h0); chk("status reset", 32'h68, rd);
      meas; chk("net disabled", 0, cn); chk("pll free", 105, cp);
      for (int s = 0; s < 4; s++) begin
         xfer(1, 12'h000, 32'(s << 1));
         repeat (20) @(posedge clk);
         xfer(1, 12'h000, 32'(s << 1 | 1));
         meas; chk("net by select", exp_sel[s], cn);
      end
      xfer(0, 12'h008, 32'h0); chk("status open", 32'h6F, rd);
      xfer(1, 12'h000, 32'h6);
      meas; chk("net gated", 0, cn); chk("pll kept", 105, cp);
      for (int i = 0; i < 8; i++) begin
         xfer(1, 12'h004, st[i]);
         xfer(1, 12'h000, ct[i]);
         meas; chk("net static", en[i], cn); chk("pll ref", ep[i], cp);
         chk("corner spare", eg[i], cg);
         xfer(0, 12'h008, 32'h0); chk("pll feed", 32'(st[i][1:0] == 2'h0), 32'(rd[3]));
      end
      um <= 1'h1;
      repeat (5) @(posedge clk);
      xfer(1, 12'h004, 32'h0); chk("locked resp", 32'h0, 32'(rs));
      xfer(0, 12'h004, 32'h0); chk("locked static", 32'h85, rd);
      um <= 1'h0;
      xfer(1, 12'h010, 32'hFFFFFFFF); chk("bad write", 32'h2, 32'(rs));
      xfer(0, 12'h010, 32'h0); chk("bad read", 32'h2, 32'(rs)); chk("bad data", 32'h0, rd);
      close_out();
   end
endmodule : global_clock_control_block_test
bind gcc_ctrl_top gcc_ctrl_sva #(.GX_VARIANT(GX_VARIANT), .LEFT_SIDE(LEFT_SIDE)) sva_i (
   .REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
   .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
   .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
   .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
   .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
   .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
   .S_AXI_RREADY_I(S_AXI_RREADY_I), .SRC_I(SRC_I), .GLOBAL_CLOCK_NET_O(GLOBAL_CLOCK_NET_O),
   .PLL_INPUT_CLOCK_O(PLL_INPUT_CLOCK_O), .CLK_PIN_FABRIC_O(CLK_PIN_FABRIC_O));
